// file: core/pmsel_pkg.sv
package pmsel_pkg;

  // ----------------------------------------------------------------
  // bus geometry
  // ----------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int NUM_CNT = 6;
  localparam int CNT_W = 40;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] SEL_A_OFS = 8'h00;
  localparam logic [7:0] SEL_B_OFS = 8'h04;
  localparam logic [7:0] CFG_BASE = 8'h10;
  localparam logic [7:0] CFG_LAST = 8'h24;
  localparam logic [7:0] CNT_BASE = 8'h40;
  localparam logic [7:0] CNT_LAST = 8'h6c;

  // ----------------------------------------------------------------
  // selector fields
  // ----------------------------------------------------------------
  localparam int CODE_HI = 31;
  localparam int CODE_LO = 25;
  localparam int MASK_HI = 24;
  localparam int MASK_LO = 9;
  localparam int KERNEL_FLAG_BIT = 3;
  localparam int USER_FLAG_BIT = 2;
  localparam int NOT_TAKEN_PREDICTED_BIT = 0;
  localparam int NOT_TAKEN_MISPREDICTED_BIT = 1;
  localparam int TAKEN_PREDICTED_BIT = 2;
  localparam int TAKEN_MISPREDICTED_BIT = 3;
  localparam logic [6:0] BRANCH_RETIRED_CODE = 7'h06;

  // ----------------------------------------------------------------
  // counter configuration fields
  // ----------------------------------------------------------------
  localparam int CHOICE_HI = 15;
  localparam int CHOICE_LO = 13;
  localparam int ENABLE_BIT = 12;
  localparam logic [2:0] RETIRE_SEL_NUM = 3'h5;
  // counters 12..17 as local 0..5; set bit means fed by selector b
  localparam logic [5:0] FEED_FROM_B = 6'h2c;
  localparam logic [31:0] SEL_RESET = 32'h0000_0000;
  localparam logic [31:0] CFG_RESET = 32'h0000_0000;

  typedef struct packed {
    logic valid;
    logic taken;
    logic mispredicted;
    logic user_mode;
  } pmsel_branch_t;

  function automatic logic [31:0] apply_be(logic [31:0] old_v, logic [31:0] new_v, logic [3:0] be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

endpackage

// file: core/pmsel_qualify.sv
`timescale 1ns/100ps
module pmsel_qualify (
  input wire logic [31:0] selector,
  input wire logic [31:0] config_word,
  input wire pmsel_pkg::pmsel_branch_t branch_evt,
  output logic hit
);
  import pmsel_pkg::*;

  logic [15:0] mask;
  logic [1:0] outcome;
  logic priv_ok;

  // only the four defined mask bits are looked at; reserved ones are ignored
  assign mask = selector[MASK_HI:MASK_LO];
  assign outcome = {branch_evt.taken, branch_evt.mispredicted};
  assign priv_ok = branch_evt.user_mode ? selector[USER_FLAG_BIT] : selector[KERNEL_FLAG_BIT];

  always_comb begin
    hit = 1'b0;
    // choice is an index among tied selectors, not an address
    if (config_word[CHOICE_HI:CHOICE_LO] == RETIRE_SEL_NUM &&
        selector[CODE_HI:CODE_LO] == BRANCH_RETIRED_CODE &&
        branch_evt.valid && priv_ok) begin
      hit = mask[outcome[1:0]];
    end
  end

endmodule

// file: core/pmsel_counter.sv
`timescale 1ns/100ps
module pmsel_counter #(
  parameter int CW = pmsel_pkg::CNT_W
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic enable,
  input wire logic hit,
  output logic [CW-1:0] count
);
  import pmsel_pkg::*;

  // plain wrap past the top, no overflow side effects
  always_ff @(posedge core_clk) begin
    if (reset) begin
      count <= '0;
    end else if (enable && hit) begin
      count <= count + CW'(1);
    end
  end

endmodule

// file: core/pmsel_top.sv
// The implementer's own choices: the Avalon-MM slave port and the address map.
`timescale 1ns/100ps
module pmsel_top #(
  parameter int CW = pmsel_pkg::CNT_W
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [pmsel_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [pmsel_pkg::DATA_W-1:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [pmsel_pkg::DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  input wire pmsel_pkg::pmsel_branch_t branch_evt
);
  import pmsel_pkg::*;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic [31:0] retire_unit_selector_a;
  logic [31:0] retire_unit_selector_b;
  logic [31:0] counter_config_reg [NUM_CNT];
  logic [CW-1:0] cnt [NUM_CNT];
  logic [NUM_CNT-1:0] hit;
  logic [NUM_CNT-1:0] cnt_en;
  logic wr_take;
  logic req_new;
  logic [31:0] next_readdata;

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  function automatic logic is_cfg(logic [7:0] a);
    return a >= CFG_BASE && a <= CFG_LAST && a[1:0] == 2'h0;
  endfunction

  function automatic logic is_cnt(logic [7:0] a);
    return a >= CNT_BASE && a <= CNT_LAST && a[1:0] == 2'h0;
  endfunction

  function automatic int cfg_idx(logic [7:0] a);
    logic [7:0] d;
    d = a - CFG_BASE;
    return int'(d[7:2]);
  endfunction

  function automatic int cnt_idx(logic [7:0] a);
    logic [7:0] d;
    d = a - CNT_BASE;
    return int'(d[7:3]);
  endfunction

  function automatic logic is_mapped(logic [7:0] a);
    return a == SEL_A_OFS || a == SEL_B_OFS || is_cfg(a) || is_cnt(a);
  endfunction

  // ----------------------------------------------------------------
  // bus handshake
  // ----------------------------------------------------------------
  // one wait cycle per access: registered readdata and registered waitrequest
  // cost a cycle but keep every output straight off a flop
  assign req_new = (avs_read || avs_write) && avs_waitrequest;
  assign wr_take = avs_write && !avs_waitrequest;

  always_ff @(posedge core_clk) begin
    if (reset) begin
      avs_waitrequest <= 1'b1;
    end else if (!avs_waitrequest) begin
      avs_waitrequest <= 1'b1;
    end else if (req_new) begin
      avs_waitrequest <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      avs_readdata <= 32'h0000_0000;
    end else if (req_new && avs_read) begin
      avs_readdata <= next_readdata;
    end
  end

  always_comb begin
    logic [CW-1:0] c;
    logic [63:0] wide;
    c = '0;
    wide = 64'h0;
    next_readdata = 32'h0000_0000;
    if (avs_address == SEL_A_OFS) begin
      next_readdata = retire_unit_selector_a;
    end else if (avs_address == SEL_B_OFS) begin
      next_readdata = retire_unit_selector_b;
    end else if (is_cfg(avs_address)) begin
      next_readdata = counter_config_reg[cfg_idx(avs_address)];
    end else if (is_cnt(avs_address)) begin
      c = cnt[cnt_idx(avs_address)];
      wide = 64'(c);
      next_readdata = avs_address[2] ? wide[63:32] : wide[31:0];
    end
  end

  // ----------------------------------------------------------------
  // event selectors
  // ----------------------------------------------------------------
  // code, mask and both privilege flags land on the same edge
  always_ff @(posedge core_clk) begin
    if (reset) begin
      retire_unit_selector_a <= SEL_RESET;
    end else if (wr_take && avs_address == SEL_A_OFS) begin
      retire_unit_selector_a <= apply_be(retire_unit_selector_a, avs_writedata, avs_byteenable);
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      retire_unit_selector_b <= SEL_RESET;
    end else if (wr_take && avs_address == SEL_B_OFS) begin
      retire_unit_selector_b <= apply_be(retire_unit_selector_b, avs_writedata, avs_byteenable);
    end
  end

  // ----------------------------------------------------------------
  // counter configuration
  // ----------------------------------------------------------------
  // byte-enabled store: a later write may redo any subset of byte lanes
  always_ff @(posedge core_clk) begin
    if (reset) begin
      for (int i = 0; i < NUM_CNT; i++) begin
        counter_config_reg[i] <= CFG_RESET;
      end
    end else if (wr_take && is_cfg(avs_address)) begin
      counter_config_reg[cfg_idx(avs_address)] <=
        apply_be(counter_config_reg[cfg_idx(avs_address)], avs_writedata, avs_byteenable);
    end
  end

  // ----------------------------------------------------------------
  // counters
  // ----------------------------------------------------------------
  // only selector and configuration words are needed; no sampling buffer
  for (genvar g = 0; g < NUM_CNT; g++) begin : g_cnt
    assign cnt_en[g] = counter_config_reg[g][ENABLE_BIT];

    pmsel_qualify u_qual (
      .selector(FEED_FROM_B[g] ? retire_unit_selector_b : retire_unit_selector_a),
      .config_word(counter_config_reg[g]),
      .branch_evt(branch_evt),
      .hit(hit[g])
    );

    pmsel_counter #(
      .CW(CW)
    ) u_cnt (
      .core_clk(core_clk),
      .reset(reset),
      .enable(cnt_en[g]),
      .hit(hit[g]),
      .count(cnt[g])
    );
  end

  // ----------------------------------------------------------------
  // assertion helpers
  // ----------------------------------------------------------------
  logic [CW-1:0] cnt0_inc;
  logic [CW-1:0] cnt2_inc;
  logic [15:0] mask_a;
  logic [1:0] outc;
  logic [15:0] mask_b;
  assign cnt0_inc = cnt[0] + CW'(1);
  assign cnt2_inc = cnt[2] + CW'(1);
  assign mask_a = retire_unit_selector_a[MASK_HI:MASK_LO];
  assign outc = {branch_evt.taken, branch_evt.mispredicted};
  assign mask_b = retire_unit_selector_b[MASK_HI:MASK_LO];

  sequence s_write_sel_a;
    wr_take && avs_address == SEL_A_OFS && avs_byteenable == 4'hf;
  endsequence

  sequence s_write_sel_b;
    wr_take && avs_address == SEL_B_OFS && avs_byteenable == 4'hf;
  endsequence

  sequence s_write_cfg0;
    wr_take && avs_address == CFG_BASE && avs_byteenable == 4'hf;
  endsequence

  sequence s_req_start;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_code_field_load: assert property (
    @(posedge core_clk) disable iff (reset)
    s_write_sel_a |=> retire_unit_selector_a[CODE_HI:CODE_LO] == $past(avs_writedata[CODE_HI:CODE_LO])
  ) else $error("selector code field not loaded");

  a_mask_field_load: assert property (
    @(posedge core_clk) disable iff (reset)
    s_write_sel_a |=> retire_unit_selector_a[MASK_HI:MASK_LO] == $past(avs_writedata[MASK_HI:MASK_LO])
  ) else $error("selector mask field not loaded");

  a_flags_together: assert property (
    @(posedge core_clk) disable iff (reset)
    s_write_sel_a |=> retire_unit_selector_a == $past(avs_writedata)
  ) else $error("selector fields not applied together");

  a_mask_gates_hit: assert property (
    @(posedge core_clk) disable iff (reset)
    hit[0] |-> mask_a[outc] && retire_unit_selector_a[CODE_HI:CODE_LO] == BRANCH_RETIRED_CODE
  ) else $error("count without enabled mask bit");

  a_choice_index: assert property (
    @(posedge core_clk) disable iff (reset)
    counter_config_reg[0][CHOICE_HI:CHOICE_LO] != RETIRE_SEL_NUM |-> !hit[0]
  ) else $error("count with wrong selector choice");

  a_priv_gate: assert property (
    @(posedge core_clk) disable iff (reset)
    hit[2] |-> (branch_evt.user_mode ? retire_unit_selector_b[USER_FLAG_BIT]
                                     : retire_unit_selector_b[KERNEL_FLAG_BIT])
  ) else $error("count at unselected privilege level");

  a_cfg_write_all: assert property (
    @(posedge core_clk) disable iff (reset)
    s_write_cfg0 |=> counter_config_reg[0] == $past(avs_writedata) ##1 $stable(counter_config_reg[0]) || wr_take
  ) else $error("configuration write lost");

  a_reset_clears: assert property (
    @(posedge core_clk)
    $past(reset) |-> counter_config_reg[5] == CFG_RESET && !cnt_en[5]
  ) else $error("configuration not cleared by reset");

  a_count_step: assert property (
    @(posedge core_clk) disable iff (reset)
    cnt_en[0] && hit[0] |=> cnt[0] == $past(cnt0_inc)
  ) else $error("counter did not step by one");

  a_count_hold: assert property (
    @(posedge core_clk) disable iff (reset)
    !(cnt_en[2] && hit[2]) |=> cnt[2] == $past(cnt[2])
  ) else $error("counter moved without event");

  a_feed_b: assert property (
    @(posedge core_clk) disable iff (reset)
    hit[3] |-> mask_b[outc] && retire_unit_selector_b[CODE_HI:CODE_LO] == BRANCH_RETIRED_CODE
  ) else $error("counter 15 not fed by selector b");

  a_wait_once: assert property (
    @(posedge core_clk) disable iff (reset)
    s_req_start |=> !avs_waitrequest ##1 avs_waitrequest
  ) else $error("bus answer not after one wait cycle");

  a_enabled_wraps: assert property (
    @(posedge core_clk) disable iff (reset)
    cnt_en[2] && hit[2] && cnt[2] == '1 |=> cnt[2] == '0 && $past(cnt2_inc) == '0
  ) else $error("counter did not wrap to zero");

  a_sel_b_load: assert property (
    @(posedge core_clk) disable iff (reset)
    s_write_sel_b |=> retire_unit_selector_b == $past(avs_writedata)
  ) else $error("selector b fields not applied together");

  a_choice_load: assert property (
    @(posedge core_clk) disable iff (reset)
    s_write_cfg0 |=> counter_config_reg[0][CHOICE_HI:CHOICE_LO] == $past(avs_writedata[CHOICE_HI:CHOICE_LO])
  ) else $error("selector choice field not loaded");

  a_cfg_lane_write: assert property (
    @(posedge core_clk) disable iff (reset)
    wr_take && avs_address == CFG_BASE && avs_byteenable == 4'h2 |=>
      counter_config_reg[0][15:8] == $past(avs_writedata[15:8]) &&
      counter_config_reg[0][31:16] == $past(counter_config_reg[0][31:16]) &&
      counter_config_reg[0][7:0] == $past(counter_config_reg[0][7:0])
  ) else $error("partial configuration write disturbed other lanes");

  a_count_disabled: assert property (
    @(posedge core_clk) disable iff (reset)
    !cnt_en[5] |=> cnt[5] == $past(cnt[5])
  ) else $error("disabled counter moved");

  a_feed_a_group: assert property (
    @(posedge core_clk) disable iff (reset)
    counter_config_reg[1][CHOICE_HI:CHOICE_LO] == counter_config_reg[0][CHOICE_HI:CHOICE_LO] &&
    counter_config_reg[4][CHOICE_HI:CHOICE_LO] == counter_config_reg[0][CHOICE_HI:CHOICE_LO]
    |-> hit[1] == hit[0] && hit[4] == hit[0]
  ) else $error("selector a group counters disagree");

  a_feed_b_group: assert property (
    @(posedge core_clk) disable iff (reset)
    counter_config_reg[3][CHOICE_HI:CHOICE_LO] == counter_config_reg[2][CHOICE_HI:CHOICE_LO] &&
    counter_config_reg[5][CHOICE_HI:CHOICE_LO] == counter_config_reg[2][CHOICE_HI:CHOICE_LO]
    |-> hit[3] == hit[2] && hit[5] == hit[2]
  ) else $error("selector b group counters disagree");

  a_mask_gates_b: assert property (
    @(posedge core_clk) disable iff (reset)
    hit[2] |-> mask_b[outc]
  ) else $error("counter 14 counted without enabled mask bit");

  a_valid_gates: assert property (
    @(posedge core_clk) disable iff (reset)
    !branch_evt.valid |-> hit == '0
  ) else $error("count without a retired branch");

  a_read_sel_a: assert property (
    @(posedge core_clk) disable iff (reset)
    avs_read && avs_waitrequest && avs_address == SEL_A_OFS |=> avs_readdata == $past(retire_unit_selector_a)
  ) else $error("selector a read returned wrong data");

  a_read_unmapped: assert property (
    @(posedge core_clk) disable iff (reset)
    avs_read && avs_waitrequest && !is_mapped(avs_address) |=> avs_readdata == '0
  ) else $error("unmapped read not zero");

  a_refuse_write: assert property (
    @(posedge core_clk) disable iff (reset)
    wr_take && !is_mapped(avs_address) |=>
      $stable(retire_unit_selector_a) && $stable(retire_unit_selector_b) && $stable(counter_config_reg[0])
  ) else $error("write to unmapped address changed state");

  a_wait_idle: assert property (
    @(posedge core_clk) disable iff (reset)
    !avs_read && !avs_write && avs_waitrequest |=> avs_waitrequest
  ) else $error("bus answered without a request");

  a_readdata_hold: assert property (
    @(posedge core_clk) disable iff (reset)
    !(req_new && avs_read) |=> $stable(avs_readdata)
  ) else $error("read data changed without a read");

  a_reset_state: assert property (
    @(posedge core_clk)
    $past(reset) |-> retire_unit_selector_a == SEL_RESET && retire_unit_selector_b == SEL_RESET && avs_waitrequest
  ) else $error("selectors or bus not idle after reset");

  a_priv_gate_a: assert property (
    @(posedge core_clk) disable iff (reset)
    hit[0] |-> (branch_evt.user_mode ? retire_unit_selector_a[USER_FLAG_BIT]
                                     : retire_unit_selector_a[KERNEL_FLAG_BIT])
  ) else $error("counter 12 counted at unselected privilege level");

endmodule

// file: tb/pmsel_top_test.sv
`timescale 1ns/100ps
module pmsel_top_test;
  import pmsel_pkg::*;
  // ----------------------------------------------------------------
  // clock, reset and design
  // ----------------------------------------------------------------
  localparam int TCW = 4;
  localparam int LIMIT = 4000;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic [ADDR_W-1:0] avs_address = '0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [DATA_W-1:0] avs_writedata = '0;
  logic [3:0] avs_byteenable = 4'h0;
  logic [DATA_W-1:0] avs_readdata;
  logic avs_waitrequest;
  pmsel_branch_t branch_evt = '0;
  int mismatches = 0;
  int tests_run = 0;
  int cycles = 0;
  logic [TCW-1:0] exp_cnt [NUM_CNT];

  always #10 core_clk = ~core_clk;

  // short counter so wrapping is reached in a few events
  pmsel_top #(.CW(TCW)) DUT (
    .core_clk(core_clk),
    .reset(reset),
    .avs_address(avs_address),
    .avs_read(avs_read),
    .avs_write(avs_write),
    .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .branch_evt(branch_evt)
  );

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic complete_run();
    $display("TB: tests_run=%0d mismatches=%0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      mismatches++;
      $display("BAD t=%0t bench timeout", $time);
      complete_run();
    end
  end

  task automatic check_word(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic bus_write(input logic [7:0] addr, input logic [31:0] data, input logic [3:0] be);
    @(posedge core_clk);
    avs_address <= addr;
    avs_writedata <= data;
    avs_byteenable <= be;
    avs_write <= 1'b1;
    @(posedge core_clk);
    while (avs_waitrequest !== 1'b0) @(posedge core_clk);
    avs_write <= 1'b0;
  endtask

  task automatic check_reg(input logic [7:0] addr, input logic [31:0] exp);
    logic [31:0] got;
    @(posedge core_clk);
    avs_address <= addr;
    avs_read <= 1'b1;
    @(posedge core_clk);
    while (avs_waitrequest !== 1'b0) @(posedge core_clk);
    got = avs_readdata;
    avs_read <= 1'b0;
    check_word(got, exp, $sformatf("read %h", addr));
  endtask

  // undefined mask bits always written as zero
  function automatic logic [31:0] sel_word(logic [6:0] code, logic [3:0] mask, logic [3:0] flags);
    return {code, 12'h000, mask, 5'h00, flags};
  endfunction

  function automatic logic [7:0] cfg_addr(int i);
    return 8'(CFG_BASE + 4 * i);
  endfunction

  task automatic send_br(input logic taken, input logic mis, input logic user);
    @(posedge core_clk);
    branch_evt <= pmsel_branch_t'({1'b1, taken, mis, user});
    @(posedge core_clk);
    branch_evt <= '0;
  endtask

  task automatic check_counters();
    for (int i = 0; i < NUM_CNT; i++) begin
      check_reg(8'(CNT_BASE + 8 * i), 32'(exp_cnt[i]));
      check_reg(8'(CNT_BASE + 8 * i + 4), 32'h0000_0000);
    end
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    check_word(32'(avs_waitrequest), 32'h0000_0001, "idle wait");
    check_reg(SEL_A_OFS, SEL_RESET);
    check_reg(SEL_B_OFS, SEL_RESET);
    for (int i = 0; i < NUM_CNT; i++) check_reg(cfg_addr(i), CFG_RESET);
    check_counters();
    $display("TB: reset test done");
  endtask

  task automatic t_setup();
    bus_write(SEL_A_OFS, sel_word(BRANCH_RETIRED_CODE, 4'h1, 4'hc), 4'hf);
    check_reg(SEL_A_OFS, 32'h0c00_020c);
    bus_write(cfg_addr(0), 32'h0000_a000, 4'hf);
    bus_write(cfg_addr(0), 32'h1234_b0ff, 4'h2);
    check_reg(cfg_addr(0), 32'h0000_b000);
    $display("TB: setup test done");
  endtask

  task automatic t_mask();
    for (int m = 0; m < 4; m++) begin
      bus_write(SEL_A_OFS, sel_word(BRANCH_RETIRED_CODE, 4'(1 << m), 4'hc), 4'hf);
      for (int o = 0; o < 4; o++) send_br(o[1], o[0], 1'b1);
      exp_cnt[0] += 1'b1;
      check_reg(CNT_BASE, 32'(exp_cnt[0]));
    end
    bus_write(SEL_A_OFS, sel_word(BRANCH_RETIRED_CODE, 4'hf, 4'hc), 4'hf);
    for (int o = 0; o < 4; o++) send_br(o[1], o[0], 1'b0);
    exp_cnt[0] += 4'h4;
    check_counters();
    $display("TB: mask test done");
  endtask

  task automatic t_filter();
    bus_write(SEL_A_OFS, sel_word(BRANCH_RETIRED_CODE, 4'hf, 4'h4), 4'hf);
    send_br(1'b1, 1'b0, 1'b0);
    send_br(1'b1, 1'b0, 1'b1);
    bus_write(SEL_A_OFS, sel_word(BRANCH_RETIRED_CODE, 4'hf, 4'h8), 4'hf);
    send_br(1'b0, 1'b1, 1'b1);
    send_br(1'b0, 1'b1, 1'b0);
    exp_cnt[0] += 4'h2;
    check_reg(CNT_BASE, 32'(exp_cnt[0]));
    bus_write(SEL_A_OFS, sel_word(7'h07, 4'hf, 4'hc), 4'hf);
    send_br(1'b1, 1'b1, 1'b1);
    check_reg(CNT_BASE, 32'(exp_cnt[0]));
    bus_write(SEL_A_OFS, sel_word(BRANCH_RETIRED_CODE, 4'hf, 4'hc), 4'hf);
    bus_write(cfg_addr(0), 32'h0000_9000, 4'hf);
    send_br(1'b1, 1'b1, 1'b1);
    check_reg(CNT_BASE, 32'(exp_cnt[0]));
    bus_write(cfg_addr(0), 32'h0000_a000, 4'hf);
    send_br(1'b1, 1'b1, 1'b1);
    check_reg(CNT_BASE, 32'(exp_cnt[0]));
    $display("TB: filter test done");
  endtask

  task automatic t_feed();
    bus_write(SEL_A_OFS, sel_word(BRANCH_RETIRED_CODE, 4'h1, 4'hc), 4'hf);
    bus_write(SEL_B_OFS, sel_word(BRANCH_RETIRED_CODE, 4'h8, 4'hc), 4'hf);
    for (int i = 0; i < NUM_CNT; i++) bus_write(cfg_addr(i), 32'h0000_b000, 4'hf);
    send_br(1'b0, 1'b0, 1'b1);
    send_br(1'b1, 1'b1, 1'b0);
    send_br(1'b1, 1'b1, 1'b1);
    for (int i = 0; i < NUM_CNT; i++) exp_cnt[i] += (FEED_FROM_B[i] ? 4'h2 : 4'h1);
    check_counters();
    $display("TB: feed test done");
  endtask

  task automatic t_wrap();
    repeat (6) send_br(1'b0, 1'b0, 1'b1);
    repeat (14) send_br(1'b1, 1'b1, 1'b1);
    for (int i = 0; i < NUM_CNT; i++) exp_cnt[i] += (FEED_FROM_B[i] ? 4'he : 4'h6);
    check_counters();
    $display("TB: wrap test done");
  endtask

  task automatic t_refuse();
    check_reg(8'h80, 32'h0000_0000);
    bus_write(CNT_BASE, 32'hffff_ffff, 4'hf);
    bus_write(8'h30, 32'hffff_ffff, 4'hf);
    check_reg(8'h30, 32'h0000_0000);
    check_reg(CNT_BASE, 32'(exp_cnt[0]));
    $display("TB: refuse test done");
  endtask

  initial begin
    foreach (exp_cnt[i]) exp_cnt[i] = '0;
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    t_reset();
    t_setup();
    t_mask();
    t_filter();
    t_feed();
    t_wrap();
    t_refuse();
    complete_run();
  end
endmodule
